// file: logic/pv_post_pkg.sv
// Shared constants for the process value post-processing block
package pv_post_pkg;
	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int CLK_HZ     = 10_000_000;
	localparam int TICK_S     = 1;
	localparam int SEC_CYCLES = CLK_HZ * TICK_S;
	// -----------------------------------------------------------------
	// Register offsets (byte addresses)
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_SMIN   = 8'h04;
	localparam logic [7:0] OFS_SMAX   = 8'h08;
	localparam logic [7:0] OFS_ZADJ   = 8'h0C;
	localparam logic [7:0] OFS_GAIN   = 8'h10;
	localparam logic [7:0] OFS_ZPOS   = 8'h14;
	localparam logic [7:0] OFS_PERIOD = 8'h18;
	localparam logic [7:0] OFS_HYST   = 8'h1C;
	localparam logic [7:0] OFS_COEF   = 8'h20;
	localparam logic [7:0] OFS_RTDREF = 8'h24;
	localparam logic [7:0] OFS_PV     = 8'h28;
	localparam logic [7:0] OFS_HI     = 8'h2C;
	localparam logic [7:0] OFS_LO     = 8'h30;
	localparam logic [7:0] OFS_INTEG  = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_LASTADJ = 8'h3C;
	// -----------------------------------------------------------------
	// Control fields
	// -----------------------------------------------------------------
	localparam int CTL_SQRT_EN  = 0;
	localparam int CTL_HSTART   = 2;
	localparam int CTL_HRESET   = 3;
	localparam int CTL_HSEL     = 4;
	localparam int CTL_ISTART   = 5;
	localparam int CTL_IRESET   = 6;
	localparam int CTL_ADJ_UPD  = 7;
	localparam int CTL_IUNIT    = 8;
	localparam int CTL_CJC_EXT  = 9;
	localparam int CTL_RTD_EN   = 10;
	localparam int CTL_TYPE_LO  = 11;
	localparam int CTL_W        = 13;
	localparam logic [1:0] IN_DC  = 2'h0;
	localparam logic [1:0] IN_TC  = 2'h1;
	localparam logic [1:0] IN_RTD = 2'h2;
	// -----------------------------------------------------------------
	// Arithmetic constants and reset values
	// -----------------------------------------------------------------
	localparam logic [15:0] LIN_LIMIT  = 16'h11EC;      // 7 % of full scale
	localparam logic [15:0] LIN_K      = 16'h0E49;      // 1/0.07 in Q8
	localparam int          LIN_SHIFT  = 8;
	localparam logic [15:0] GAIN_ONE   = 16'h4000;      // 1.0 in Q14
	localparam int          GAIN_SHIFT = 14;
	localparam logic [19:0] K_HOUR     = 20'h0_1234;    // 2^24/3600
	localparam logic [19:0] K_MIN      = 20'h4_4444;    // 2^24/60
	localparam int          K_SHIFT    = 24;
	localparam logic [15:0] RTD_NOM    = 16'h0064;
	localparam logic [15:0] SMAX_RST   = 16'h7FFF;
	localparam logic [15:0] PERIOD_RST = 16'h00B4;
	localparam logic [15:0] NOTICE_RST = 16'h001E;
endpackage

// file: logic/pv_isqrt.sv
// Combinational integer square root
`timescale 1ns/1ps
`default_nettype none
module pv_isqrt #(
	parameter int W = 16
) (
	input  wire logic [2*W-1:0] rad_i,
	output logic      [W-1:0]   root_o
);
	if (W < 2) begin : g_chk
		$error("pv_isqrt: W too small");
	end

	logic [W-1:0]   cand;
	logic [2*W-1:0] sq;

	// Bitwise trial from the top bit down
	always_comb begin
		root_o = '0;
		cand   = '0;
		sq     = '0;
		for (int i = W - 1; i >= 0; i--) begin
			cand = root_o | (W'(1) << i);
			sq   = (2*W)'(cand) * (2*W)'(cand);
			if (sq <= rad_i) begin
				root_o = cand;
			end
		end
	end
endmodule
`default_nettype wire

// file: logic/pv_hold_detect.sv
// Peak/bottom and top/valley hold detector
`timescale 1ns/1ps
`default_nettype none
module pv_hold_detect #(
	parameter int W = 16
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                valid_i,
	input  wire logic                start_i,
	input  wire logic                clear_i,
	input  wire logic                tv_mode_i,
	input  wire logic signed [W-1:0] pv_i,
	input  wire logic        [W-1:0] hyst_i,
	output logic signed      [W-1:0] hi_o,
	output logic signed      [W-1:0] lo_o
);
	if (W < 2) begin : g_chk
		$error("pv_hold_detect: W too small");
	end

	typedef enum logic [1:0] {
		TV_IDLE = 2'b00,
		TV_RISE = 2'b01,
		TV_FALL = 2'b11
	} tv_state_t;

	tv_state_t               state_q;
	logic                    armed_q;
	logic signed [W-1:0]     ext_q;
	logic signed [W+1:0]     pv_x;
	logic signed [W+1:0]     ext_x;
	logic signed [W+1:0]     hy_x;

	assign pv_x  = (W+2)'(pv_i);
	assign ext_x = (W+2)'(ext_q);
	assign hy_x  = signed'((W+2)'(hyst_i));

	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			hi_o    <= '0;
			lo_o    <= '0;
			ext_q   <= '0;
			armed_q <= 1'b0;
			state_q <= TV_IDLE;
		end else if (!start_i) begin
			armed_q <= 1'b0;
			state_q <= TV_IDLE;
		end else if (valid_i) begin
			if (!armed_q) begin
				armed_q <= 1'b1;
				hi_o    <= pv_i;
				lo_o    <= pv_i;
				ext_q   <= pv_i;
				state_q <= TV_RISE;
			end else if (!tv_mode_i) begin
				if (pv_i > hi_o) begin
					hi_o <= pv_i;
				end
				if (pv_i < lo_o) begin
					lo_o <= pv_i;
				end
			end else begin
				case (state_q)
					TV_RISE: begin
						if (pv_x > ext_x) begin
							ext_q <= pv_i;
						end else if (pv_x < ext_x - hy_x) begin
							hi_o    <= ext_q;
							ext_q   <= pv_i;
							state_q <= TV_FALL;
						end
					end
					TV_FALL: begin
						if (pv_x < ext_x) begin
							ext_q <= pv_i;
						end else if (pv_x > ext_x + hy_x) begin
							lo_o    <= ext_q;
							ext_q   <= pv_i;
							state_q <= TV_RISE;
						end
					end
					default: begin
						state_q <= TV_RISE;
					end
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	a_hold_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		clear_i |=> (hi_o == '0) && (lo_o == '0))
		else $error("held values not zero after clear");
	a_hold_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		!start_i && !clear_i |=> $stable(hi_o) && $stable(lo_o))
		else $error("held values moved while hold is off");
	a_peak_order: assert property (@(posedge clk_i) disable iff (rst_i)
		armed_q && !tv_mode_i && start_i && !clear_i && valid_i
		|=> hi_o >= $past(pv_i) && lo_o <= $past(pv_i))
		else $error("peak or bottom missed a sample");
	a_tv_hyst: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == TV_RISE && tv_mode_i && start_i && !clear_i && valid_i
		&& pv_x <= ext_x && pv_x >= ext_x - hy_x |=> $stable(hi_o))
		else $error("top taken inside hysteresis");
	c_top_seen: cover property (@(posedge clk_i) disable iff (rst_i)
		state_q == TV_RISE ##1 state_q == TV_FALL);
endmodule
`default_nettype wire

// file: logic/process_value_post_processing.sv
// Process value post-processing with Wishbone register slave
// Notes on behaviour
// - Root of DC input when enabled
// - Root only when scale max exceeds min
// - Linear transfer at or below seven percent
// - Zero adjustment adds parallel offset
// - Span gain pivots about the adjustment position
// - Adjustment values apply live, no restart
// - Adjustment anchored at chosen position
// - Update bit records current day
// - Notice flag ahead of period end, end flag after period
// - Peak/bottom tracked during hold start
// - Hold reset zeroes peak and bottom
// - Top/valley detection with hysteresis
// - Hold reset zeroes top and valley
// - Select one hold mode, shared results
// - Integration time base hours or minutes
// - Accumulate integral while start is on
// - Integral reset clears to zero
// - Coefficient scales integral against overflow
// - Internal or external cold junction choice
// - Reference resistance correction when enabled
`timescale 1ns/1ps
`default_nettype none
module process_value_post_processing #(
	parameter int SEC_CYCLES = pv_post_pkg::SEC_CYCLES
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [7:0]         adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	input  wire logic [15:0]        raw_i,
	input  wire logic               raw_valid_i,
	input  wire logic signed [15:0] cj_temp_i,
	input  wire logic [15:0]        day_i,
	output logic signed [15:0]      pv_o,
	output logic                    pv_valid_o
);
	if (SEC_CYCLES < 2) begin : g_chk
		$error("SEC_CYCLES too small");
	end

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	logic [pv_post_pkg::CTL_W-1:0] ctrl_q;
	logic signed [15:0]            smin_q;
	logic signed [15:0]            smax_q;
	logic signed [15:0]            zadj_q;
	logic [15:0]                   gain_q;
	logic signed [15:0]            zpos_q;
	logic [15:0]                   period_q;
	logic [15:0]                   notice_q;
	logic [15:0]                   hyst_q;
	logic [3:0]                    coef_q;
	logic [15:0]                   rtdref_q;
	logic [15:0]                   lastadj_q;
	logic                          adjvalid_q;
	logic signed [63:0]            acc_q;
	logic [31:0]                   sec_cnt_q;
	logic                          sec_tick_q;
	logic signed [15:0]            hi_v;
	logic signed [15:0]            lo_v;

	logic        req;
	logic        wr_now;
	logic [31:0] rd_mux;
	logic [31:0] wv;
	logic [31:0] integ;
	logic [15:0] elapsed;
	logic        notice_flag;
	logic        end_flag;
	logic [1:0]  in_type;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign in_type = ctrl_q[pv_post_pkg::CTL_TYPE_LO +: 2];

	// -----------------------------------------------------------------
	// Wishbone slave: ack one cycle after the request
	// -----------------------------------------------------------------
	assign req    = cyc_i && stb_i && !ack_o;
	assign wr_now = cyc_i && stb_i && we_i && ack_o;
	assign wv     = merge(rd_mux, dat_i, sel_i);

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (adr_i)
			pv_post_pkg::OFS_CTRL:    rd_mux = 32'(ctrl_q);
			pv_post_pkg::OFS_SMIN:    rd_mux = {16'h0000, smin_q};
			pv_post_pkg::OFS_SMAX:    rd_mux = {16'h0000, smax_q};
			pv_post_pkg::OFS_ZADJ:    rd_mux = {16'h0000, zadj_q};
			pv_post_pkg::OFS_GAIN:    rd_mux = {16'h0000, gain_q};
			pv_post_pkg::OFS_ZPOS:    rd_mux = {16'h0000, zpos_q};
			pv_post_pkg::OFS_PERIOD:  rd_mux = {notice_q, period_q};
			pv_post_pkg::OFS_HYST:    rd_mux = {16'h0000, hyst_q};
			pv_post_pkg::OFS_COEF:    rd_mux = {28'h000_0000, coef_q};
			pv_post_pkg::OFS_RTDREF:  rd_mux = {16'h0000, rtdref_q};
			pv_post_pkg::OFS_PV:      rd_mux = {16'h0000, pv_o};
			pv_post_pkg::OFS_HI:      rd_mux = {16'h0000, hi_v};
			pv_post_pkg::OFS_LO:      rd_mux = {16'h0000, lo_v};
			pv_post_pkg::OFS_INTEG:   rd_mux = integ;
			pv_post_pkg::OFS_STATUS:  rd_mux = {29'h0000_0000, adjvalid_q,
				end_flag, notice_flag};
			pv_post_pkg::OFS_LASTADJ: rd_mux = {16'h0000, lastadj_q};
			default:                  rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			if (req) begin
				dat_o <= rd_mux;
			end
		end
	end

	// Software-written settings, applied live on the next sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q   <= '0;
			smin_q   <= 16'h0000;
			smax_q   <= pv_post_pkg::SMAX_RST;
			zadj_q   <= 16'h0000;
			gain_q   <= pv_post_pkg::GAIN_ONE;
			zpos_q   <= 16'h0000;
			period_q <= pv_post_pkg::PERIOD_RST;
			notice_q <= pv_post_pkg::NOTICE_RST;
			hyst_q   <= 16'h0000;
			coef_q   <= 4'h0;
			rtdref_q <= pv_post_pkg::RTD_NOM;
		end else if (wr_now) begin
			case (adr_i)
				pv_post_pkg::OFS_CTRL: begin
					ctrl_q <= wv[pv_post_pkg::CTL_W-1:0];
					ctrl_q[pv_post_pkg::CTL_ADJ_UPD] <= 1'b0;
				end
				pv_post_pkg::OFS_SMIN:   smin_q   <= wv[15:0];
				pv_post_pkg::OFS_SMAX:   smax_q   <= wv[15:0];
				pv_post_pkg::OFS_ZADJ:   zadj_q   <= wv[15:0];
				pv_post_pkg::OFS_GAIN:   gain_q   <= wv[15:0];
				pv_post_pkg::OFS_ZPOS:   zpos_q   <= wv[15:0];
				pv_post_pkg::OFS_PERIOD: begin
					period_q <= wv[15:0];
					notice_q <= wv[31:16];
				end
				pv_post_pkg::OFS_HYST:   hyst_q   <= wv[15:0];
				pv_post_pkg::OFS_COEF:   coef_q   <= wv[3:0];
				pv_post_pkg::OFS_RTDREF: rtdref_q <= wv[15:0];
				default: begin
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Conversion path
	// -----------------------------------------------------------------
	logic               sqrt_act;
	logic [15:0]        root;
	logic [31:0]        lin_prod;
	logic [15:0]        lin_v;
	logic [15:0]        yf;
	logic signed [16:0] span;
	logic signed [33:0] scl_prod;
	logic signed [31:0] scaled;
	logic signed [31:0] comp;
	logic signed [47:0] gain_prod;
	logic signed [31:0] adj;
	logic signed [15:0] adj_sat;

	pv_isqrt #(
		.W(16)
	) u_sqrt (
		.rad_i  ({raw_i, 16'h0000}),
		.root_o (root)
	);

	always_comb begin
		sqrt_act = ctrl_q[pv_post_pkg::CTL_SQRT_EN] && (in_type == pv_post_pkg::IN_DC)
			&& (smax_q > smin_q);
		lin_prod = 32'(raw_i) * 32'(pv_post_pkg::LIN_K);
		lin_v    = 16'(lin_prod >> pv_post_pkg::LIN_SHIFT);
		if (sqrt_act) begin
			yf = (root <= pv_post_pkg::LIN_LIMIT) ? lin_v : root;
		end else begin
			yf = raw_i;
		end
		span     = 17'(smax_q) - 17'(smin_q);
		scl_prod = 34'(signed'({1'b0, yf})) * 34'(span);
		scaled   = 32'(smin_q) + 32'(scl_prod >>> 16);
		comp     = scaled;
		if (in_type == pv_post_pkg::IN_TC && !ctrl_q[pv_post_pkg::CTL_CJC_EXT]) begin
			comp = scaled + 32'(cj_temp_i);
		end else if (in_type == pv_post_pkg::IN_RTD && ctrl_q[pv_post_pkg::CTL_RTD_EN]) begin
			comp = scaled + 32'(signed'({1'b0, pv_post_pkg::RTD_NOM}))
				- 32'(signed'({1'b0, rtdref_q}));
		end
		// Gain pivots about the position, then the offset shifts the line
		gain_prod = 48'(comp - 32'(zpos_q)) * 48'(signed'({1'b0, gain_q}));
		adj       = 32'(zpos_q) + 32'(zadj_q)
			+ 32'(gain_prod >>> pv_post_pkg::GAIN_SHIFT);
		if (adj > 32'sd32767) begin
			adj_sat = 16'sh7FFF;
		end else if (adj < -32'sd32768) begin
			adj_sat = -16'sh8000;
		end else begin
			adj_sat = adj[15:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pv_o       <= 16'h0000;
			pv_valid_o <= 1'b0;
		end else begin
			pv_valid_o <= raw_valid_i;
			if (raw_valid_i) begin
				pv_o <= adj_sat;
			end
		end
	end

	// -----------------------------------------------------------------
	// Hold detection
	// -----------------------------------------------------------------
	pv_hold_detect #(
		.W(16)
	) u_hold (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.valid_i   (pv_valid_o),
		.start_i   (ctrl_q[pv_post_pkg::CTL_HSTART]),
		.clear_i   (ctrl_q[pv_post_pkg::CTL_HRESET]),
		.tv_mode_i (ctrl_q[pv_post_pkg::CTL_HSEL]),
		.pv_i      (pv_o),
		.hyst_i    (hyst_q),
		.hi_o      (hi_v),
		.lo_o      (lo_v)
	);

	// -----------------------------------------------------------------
	// Adjustment period tracking
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lastadj_q  <= 16'h0000;
			adjvalid_q <= 1'b0;
		end else if (wr_now && adr_i == pv_post_pkg::OFS_CTRL
				&& wv[pv_post_pkg::CTL_ADJ_UPD]) begin
			lastadj_q  <= day_i;
			adjvalid_q <= 1'b1;
		end
	end

	assign elapsed     = day_i - lastadj_q;
	assign end_flag    = adjvalid_q && (elapsed >= period_q);
	assign notice_flag = adjvalid_q && (end_flag ||
		(17'(elapsed) + 17'(notice_q) >= 17'(period_q)));

	// -----------------------------------------------------------------
	// Integration
	// -----------------------------------------------------------------
	logic signed [20:0] kk;
	logic signed [36:0] iprod;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sec_cnt_q  <= 32'h0000_0000;
			sec_tick_q <= 1'b0;
		end else if (sec_cnt_q == 32'(SEC_CYCLES - 1)) begin
			sec_cnt_q  <= 32'h0000_0000;
			sec_tick_q <= 1'b1;
		end else begin
			sec_cnt_q  <= sec_cnt_q + 32'h0000_0001;
			sec_tick_q <= 1'b0;
		end
	end

	assign kk = ctrl_q[pv_post_pkg::CTL_IUNIT] ? signed'({1'b0, pv_post_pkg::K_MIN})
		: signed'({1'b0, pv_post_pkg::K_HOUR});
	assign iprod = 37'(pv_o) * 37'(kk);
	assign integ = 32'(acc_q >>> (pv_post_pkg::K_SHIFT + 32'(coef_q)));

	always_ff @(posedge clk_i) begin
		if (rst_i || ctrl_q[pv_post_pkg::CTL_IRESET]) begin
			acc_q <= 64'sh0000_0000_0000_0000;
		end else if (ctrl_q[pv_post_pkg::CTL_ISTART] && sec_tick_q) begin
			acc_q <= acc_q + 64'(iprod);
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> ack_o ##1 !ack_o)
		else $error("bus answer not one cycle after request");
	a_pv_latency: assert property (@(posedge clk_i) disable iff (rst_i)
		raw_valid_i |=> pv_valid_o && pv_o == $past(adj_sat))
		else $error("process value not delivered after sample");
	a_root_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!(smax_q > smin_q) |-> yf == raw_i)
		else $error("root taken with inverted scaling");
	a_adj_record: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_now && adr_i == pv_post_pkg::OFS_CTRL && wv[pv_post_pkg::CTL_ADJ_UPD]
		|=> adjvalid_q && lastadj_q == $past(day_i))
		else $error("adjustment day not recorded");
	a_end_notice: assert property (@(posedge clk_i) disable iff (rst_i)
		end_flag |-> notice_flag)
		else $error("end flag without notice flag");
	a_integ_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q[pv_post_pkg::CTL_IRESET] |=> integ == 32'h0000_0000)
		else $error("integral not cleared");
	a_integ_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_q[pv_post_pkg::CTL_ISTART] && !ctrl_q[pv_post_pkg::CTL_IRESET]
		|=> $stable(acc_q))
		else $error("integral moved while stopped");
	c_lin_region: cover property (@(posedge clk_i) disable iff (rst_i)
		raw_valid_i && sqrt_act && root <= pv_post_pkg::LIN_LIMIT);
	c_end_flag: cover property (@(posedge clk_i) disable iff (rst_i)
		!end_flag ##1 end_flag);
	c_integ_step: cover property (@(posedge clk_i) disable iff (rst_i)
		sec_tick_q && ctrl_q[pv_post_pkg::CTL_ISTART]);
endmodule
`default_nettype wire

// file: verif/pv_cpu_model.sv
// Controller CPU model: classic Wishbone master
`timescale 1ns/1ps
`default_nettype none
module pv_cpu_model (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] dat_o
);
	initial begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	end
	// One cycle, held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
		@(posedge clk_i);
		while (ack_i !== 1'b1) @(posedge clk_i);
		q = dat_i;
		{cyc_o, stb_o} <= 2'b00;
		@(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// file: verif/process_value_post_processing_bench.sv
// Self-checking bench for the process value post-processing block
`timescale 1ns/1ps
`default_nettype none
module process_value_post_processing_bench;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               cyc, stb, we, ack, pv_valid;
	logic               raw_valid = 1'b0;
	logic        [7:0]  adr;
	logic        [3:0]  sel;
	logic        [31:0] wdat, rdat, q;
	logic        [15:0] raw = 16'h0;
	logic        [15:0] day = 16'h0;
	logic signed [15:0] cj = 16'h0020;
	logic signed [15:0] pv;
	int                 n_fail = 0;
	int                 tests_run = 0;
	logic        [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
		8'h18, 8'h1C, 8'h20, 8'h24, 8'h38, 8'h40};
	logic        [31:0] rv [12] = '{32'h0, 32'h0, 32'h7FFF, 32'h0, 32'h4000, 32'h0,
		32'h001E_00B4, 32'h0, 32'h0, 32'h64, 32'h0, 32'h0};
	// ctrl, smin, smax, zadj, gain, zpos, raw, expected pv
	logic        [127:0] rows [12] = '{
		128'h0000_0000_1000_0000_4000_0000_4000_0400,
		128'h0001_0000_1000_0000_4000_0000_4000_0800,
		128'h0001_0000_1000_0000_4000_0000_0010_000E,
		128'h0001_1000_0000_0000_4000_0000_4000_0C00,
		128'h0000_0000_1000_0005_4000_0000_4000_0405,
		128'h0000_0000_1000_0000_6000_0000_4000_0600,
		128'h0000_0000_1000_0000_6000_0100_4000_0580,
		128'h0800_0000_1000_0000_4000_0000_4000_0420,
		128'h0A00_0000_1000_0000_4000_0000_4000_0400,
		128'h1400_0000_1000_0000_4000_0000_4000_0404,
		128'h1000_0000_1000_0000_4000_0000_4000_0400,
		128'h0801_0000_1000_0000_4000_0000_4000_0420};

	always #50 clk = ~clk;

	pv_cpu_model cpu (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

	process_value_post_processing #(.SEC_CYCLES(20)) dut (.clk_i(clk), .rst_i(rst),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack), .raw_i(raw), .raw_valid_i(raw_valid),
		.cj_temp_i(cj), .day_i(day), .pv_o(pv), .pv_valid_o(pv_valid));

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		cpu.xfer(1'b1, a, d, 4'hF, x);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] x;
		cpu.xfer(1'b0, a, 32'h0, 4'hF, x);
		chk(nm, e, x);
	endtask
	task automatic smp(input logic [15:0] r, input logic [15:0] e);
		raw <= r;
		raw_valid <= 1'b1;
		@(posedge clk);
		raw_valid <= 1'b0;
		#1;
		chk("pv_valid", 32'h1, {31'h0, pv_valid});
		chk("pv", {16'h0, e}, {16'h0, pv});
		@(posedge clk);
	endtask
	task automatic hs(input logic [15:0] r);
		smp(r, {4'h0, r[15:4]});
	endtask
	task automatic integ(input logic [31:0] c, input logic [3:0] k, input logic [19:0] kv);
		logic [63:0] p;
		p = 64'h400 * kv;
		wr(8'h20, {28'h0, k});
		wr(8'h00, 32'h0040);
		wr(8'h00, c);
		repeat (300) @(posedge clk);
		wr(8'h00, 32'h0);
		cpu.xfer(1'b0, 8'h34, 32'h0, 4'hF, q);
		chk("integral", 32'h1, {31'h0, (q >= 32'((14 * p) >> (24 + k)))
			&& (q <= 32'((17 * p) >> (24 + k)))});
	endtask
	task automatic dchk(input logic [15:0] d, input logic [31:0] e);
		day <= d;
		@(posedge clk);
		rd(8'h38, e, "status");
	endtask
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 12; i++) rd(ra[i], rv[i], "reset value");
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0, "unmapped");
		wr(8'h24, 32'h0060);
		for (int i = 0; i < 12; i++) begin
			for (int k = 0; k < 6; k++) wr(8'(4 * k), {16'h0, rows[i][127 - 16 * k -: 16]});
			smp(rows[i][31:16], rows[i][15:0]);
		end
		wr(8'h28, 32'h1234);
		rd(8'h28, 32'h0420, "pv read-only");
		wr(8'h00, 32'h0008);
		wr(8'h00, 32'h0004);
		hs(16'h2000);
		hs(16'h5000);
		hs(16'h1000);
		hs(16'h3000);
		rd(8'h2C, 32'h0500, "peak");
		rd(8'h30, 32'h0100, "bottom");
		wr(8'h00, 32'h0000);
		hs(16'h7000);
		rd(8'h2C, 32'h0500, "peak kept");
		wr(8'h00, 32'h0008);
		rd(8'h2C, 32'h0, "peak cleared");
		rd(8'h30, 32'h0, "bottom cleared");
		wr(8'h1C, 32'h0080);
		wr(8'h00, 32'h0018);
		wr(8'h00, 32'h0014);
		hs(16'h2000);
		hs(16'h4000);
		hs(16'h3A00);
		hs(16'h6000);
		hs(16'h5A00);
		rd(8'h2C, 32'h0200, "top within hysteresis");
		hs(16'h4000);
		rd(8'h2C, 32'h0600, "top");
		wr(8'h00, 32'h0018);
		rd(8'h2C, 32'h0, "top cleared");
		rd(8'h30, 32'h0, "valley cleared");
		hs(16'h4000);
		integ(32'h0120, 4'h0, pv_post_pkg::K_MIN);
		integ(32'h0020, 4'h0, pv_post_pkg::K_HOUR);
		integ(32'h0120, 4'h1, pv_post_pkg::K_MIN);
		wr(8'h00, 32'h0040);
		rd(8'h34, 32'h0, "integral cleared");
		day <= 16'h0064;
		wr(8'h00, 32'h0080);
		rd(8'h3C, 32'h0064, "last adjust day");
		dchk(16'h00F9, 32'h4);
		dchk(16'h00FA, 32'h5);
		dchk(16'h0117, 32'h5);
		dchk(16'h0118, 32'h7);
		cpu.xfer(1'b1, 8'h1C, 32'hFFFF_FF55, 4'h1, q);
		rd(8'h1C, 32'h0055, "hysteresis byte lane");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("pv after reset", 32'h0, {16'h0, pv});
		chk("pv_valid after reset", 32'h0, {31'h0, pv_valid});
		@(posedge clk);
		rd(8'h38, 32'h0, "status after reset");
		rd(8'h1C, 32'h0, "hysteresis after reset");
		give_verdict;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		give_verdict;
	end
endmodule
`default_nettype wire
